// ### core/rpp_defs.svh
// Constants for the RMS channel post-processing block
`ifndef RPP_DEFS_SVH
`define RPP_DEFS_SVH

// ==========================================================
// Channel count and range codes (1 = 5.0 V down to 4 = 0.5 V)
`define RPP_CHANNELS 8
`define RPP_RANGE_5V0 3'h1
`define RPP_RANGE_2V5 3'h2
`define RPP_RANGE_1V0 3'h3
`define RPP_RANGE_0V5 3'h4

// ==========================================================
// Nominal, full-scale RMS and full-scale peak, all in mV
`define RPP_NOM_5V0 16'h1388
`define RPP_NOM_2V5 16'h09C4
`define RPP_NOM_1V0 16'h03E8
`define RPP_NOM_0V5 16'h01F4
`define RPP_FS_RMS_5V0 16'h1B9E
`define RPP_FS_RMS_2V5 16'h0DCF
`define RPP_FS_RMS_1V0 16'h0586
`define RPP_FS_RMS_0V5 16'h02C3
`define RPP_FS_PK_5V0 16'h2710
`define RPP_FS_PK_2V5 16'h1388
`define RPP_FS_PK_1V0 16'h07D0
`define RPP_FS_PK_0V5 16'h03E8

// ==========================================================
// Scaling: milli-units = raw_mV * scaling * mult / 5000
`define RPP_MULT_5V0 4'h1
`define RPP_MULT_2V5 4'h2
`define RPP_MULT_1V0 4'h5
`define RPP_MULT_0V5 4'hA
`define RPP_SCALE_DIV 46'h0000000001388
`define RPP_SCALE_DEFAULT 24'h001388

// ==========================================================
// Phase limits in hundredths of a degree, filter limits
`define RPP_PHASE_MAX_50HZ 16'h02EE
`define RPP_PHASE_MAX_60HZ 16'h0384
`define RPP_FILTER_MAX_MS 15'h4E84
`define RPP_MEAS_INTERVAL_MS 32'h00000001
`define RPP_ALPHA_UNITY 17'h10000

// ==========================================================
// Alarm bit positions
`define RPP_V_CLIP 0
`define RPP_V_HIGH 1
`define RPP_V_LOW 2
`define RPP_I_CLIP 3
`define RPP_I_HIGH 4
`define RPP_I_LOW 5

`endif

// ### core/rpp_pkg.sv
// Types shared by the RMS channel post-processing block
package rpp_pkg;

  // ========================================================
  // Per-input settings: range_select holds the range number
  typedef struct packed {
    logic [2:0] range_select;
    logic [23:0] scaling;
    logic signed [31:0] high_level;
    logic signed [31:0] low_level;
  } rpp_input_cfg_s;

  typedef struct packed {
    logic disable_channel;
    rpp_input_cfg_s voltage;
    rpp_input_cfg_s current;
    logic line_60hz;
    logic signed [15:0] phase_hundredths;
    logic [14:0] filter_ms;
    logic latch_enable;
    logic user_correction_enable;
  } rpp_chan_cfg_s;

  // ========================================================
  // Correction terms, A and B in Q16.16, C in milli-units
  typedef struct packed {
    logic signed [31:0] a;
    logic signed [31:0] b;
    logic signed [31:0] c;
  } rpp_poly_s;

  typedef struct packed {
    rpp_poly_s voltage;
    rpp_poly_s current;
  } rpp_cal_s;

  typedef struct packed {
    logic [15:0] v_rms;
    logic [15:0] v_peak;
    logic [15:0] i_rms;
    logic [15:0] i_peak;
  } rpp_meas_s;

  typedef struct packed {
    logic signed [31:0] voltage_rms;
    logic signed [31:0] current_rms;
    logic [5:0] alarms;
    logic config_error;
    logic active;
  } rpp_result_s;

endpackage

// ### core/rpp_channel_postprocess.sv
// Eight-channel RMS scaling, correction, filtering and alarms
`timescale 1ns/10ps
`include "rpp_defs.svh"

// Function
// [RULE1] Eight independently configured channels
// [RULE2] Disabled channel stops operating
// [RULE3] Four ranges, default 5.0 V
// [RULE4] Voltage and current select ranges separately
// [RULE5] Range numbers one to four, descending
// [RULE6] Nominal input reads as scaling value
// [RULE7] High alarm at or above threshold
// [RULE8] Low alarm at or below threshold
// [RULE9] Line frequency 50 or 60 Hz
// [RULE10] Phase correction limit 7.5 or 9.0
// [RULE11] Phase out of range flags error
// [RULE12] Filter constant ms, zero disables, max 20100
// [RULE13] Latched alarms stay set
// [RULE14] Unlatch bit toggle clears latched alarm
// [RULE15] Enabled correction takes output-table terms
// [RULE16] Disabling correction drops old terms
// [RULE17] Correction is A x squared plus Bx plus C
// [RULE18] Correction off reports raw values
// [RULE19] Controller sets signal level to range
// [RULE20] New configuration captures terms for later
// [RULE21] Clip alarm when peak reaches full scale
// [RULE22] First-order recursive filter per measurement
module rpp_channel_postprocess (
  input wire logic clock,
  input wire logic rst,
  input wire logic cfg_valid,
  input wire logic [2:0] cfg_channel,
  input wire rpp_pkg::rpp_chan_cfg_s cfg_in,
  input wire rpp_pkg::rpp_cal_s [7:0] cal_table,
  input wire logic [7:0][5:0] unlatch_table,
  input wire logic meas_valid,
  input wire logic [2:0] meas_channel,
  input wire rpp_pkg::rpp_meas_s meas_in,
  output rpp_pkg::rpp_result_s [7:0] result
);
  import rpp_pkg::*;

  localparam rpp_input_cfg_s IN_DEFAULT = '{
    range_select: `RPP_RANGE_5V0, scaling: `RPP_SCALE_DEFAULT,
    high_level: 32'sh0, low_level: 32'sh0};
  localparam rpp_chan_cfg_s CFG_DEFAULT = '{
    disable_channel: 1'b0, voltage: IN_DEFAULT, current: IN_DEFAULT,
    line_60hz: 1'b1, phase_hundredths: 16'sh0, filter_ms: 15'h0,
    latch_enable: 1'b0, user_correction_enable: 1'b0};

  // ========================================================
  // Range decoding
  function automatic logic [3:0] rpp_mult(input logic [2:0] r);
    case (r)
      `RPP_RANGE_2V5: rpp_mult = `RPP_MULT_2V5;
      `RPP_RANGE_1V0: rpp_mult = `RPP_MULT_1V0;
      `RPP_RANGE_0V5: rpp_mult = `RPP_MULT_0V5;
      default: rpp_mult = `RPP_MULT_5V0;
    endcase
  endfunction

  function automatic logic [15:0] rpp_fs_rms(input logic [2:0] r);
    case (r)
      `RPP_RANGE_2V5: rpp_fs_rms = `RPP_FS_RMS_2V5;
      `RPP_RANGE_1V0: rpp_fs_rms = `RPP_FS_RMS_1V0;
      `RPP_RANGE_0V5: rpp_fs_rms = `RPP_FS_RMS_0V5;
      default: rpp_fs_rms = `RPP_FS_RMS_5V0;
    endcase
  endfunction

  function automatic logic [15:0] rpp_fs_peak(input logic [2:0] r);
    case (r)
      `RPP_RANGE_2V5: rpp_fs_peak = `RPP_FS_PK_2V5;
      `RPP_RANGE_1V0: rpp_fs_peak = `RPP_FS_PK_1V0;
      `RPP_RANGE_0V5: rpp_fs_peak = `RPP_FS_PK_0V5;
      default: rpp_fs_peak = `RPP_FS_PK_5V0;
    endcase
  endfunction

  function automatic logic rpp_range_ok(input logic [2:0] r);
    rpp_range_ok = (r >= `RPP_RANGE_5V0) && (r <= `RPP_RANGE_0V5);
  endfunction

  // ========================================================
  // Arithmetic
  // Readings above full-scale RMS are clamped, so the product
  // stays well inside 31 bits for every range and scaling.
  function automatic logic signed [31:0] rpp_scale(
    input logic [15:0] raw,
    input logic [2:0] r,
    input logic [23:0] s
  );
    logic [15:0] x;
    logic [45:0] p;
    x = (raw > rpp_fs_rms(r)) ? rpp_fs_rms(r) : raw;
    p = (46'(x) * 46'(s) * 46'(rpp_mult(r))) / `RPP_SCALE_DIV;
    rpp_scale = signed'(p[31:0]);
  endfunction

  function automatic logic signed [31:0] rpp_poly(
    input logic signed [31:0] x,
    input rpp_poly_s t
  );
    logic signed [63:0] x2;
    logic signed [95:0] y;
    x2 = 64'(x) * 64'(x);
    y = ((96'(t.a) * 96'(x2)) >>> 16) + ((96'(t.b) * 96'(x)) >>> 16)
      + 96'(t.c);
    if (y > 96'sh7FFFFFFF) begin
      rpp_poly = 32'sh7FFFFFFF;
    end else if (y < -96'sh80000000) begin
      rpp_poly = -32'sh7FFFFFFF - 32'sh1;
    end else begin
      rpp_poly = 32'(y);
    end
  endfunction

  function automatic logic signed [31:0] rpp_filter(
    input logic signed [31:0] prev,
    input logic signed [31:0] x,
    input logic [16:0] alpha
  );
    logic signed [49:0] d;
    d = (50'(x) - 50'(prev)) * 50'(signed'({1'b0, alpha}));
    rpp_filter = prev + 32'(d >>> 16);
  endfunction

  // Coefficient dt / (tau + dt) in Q16; one divide per config
  function automatic logic [16:0] rpp_alpha(input logic [14:0] ms);
    logic [31:0] q;
    q = (`RPP_MEAS_INTERVAL_MS << 16)
      / (32'(ms) + `RPP_MEAS_INTERVAL_MS);
    rpp_alpha = (ms == 15'h0) ? `RPP_ALPHA_UNITY : q[16:0];
  endfunction

  function automatic logic rpp_cfg_bad(input rpp_chan_cfg_s c);
    logic [15:0] mag;
    logic [15:0] lim;
    mag = c.phase_hundredths[15] ? 16'(-c.phase_hundredths)
                                 : c.phase_hundredths;
    lim = c.line_60hz ? `RPP_PHASE_MAX_60HZ : `RPP_PHASE_MAX_50HZ;
    rpp_cfg_bad = (mag > lim) || (c.filter_ms > `RPP_FILTER_MAX_MS)
      || !rpp_range_ok(c.voltage.range_select)
      || !rpp_range_ok(c.current.range_select);
  endfunction

  // ========================================================
  // State
  rpp_chan_cfg_s [7:0] cfg_q;
  rpp_cal_s [7:0] poly_q;
  logic [7:0][16:0] alpha_q;
  logic [7:0] err_q;
  logic [7:0] seed_q;
  logic [7:0][1:0][31:0] filt_q;
  logic [7:0][5:0] alarm_q;
  logic [7:0][5:0] unl_prev_q;
  logic [7:0][5:0] tog;
  rpp_chan_cfg_s c;
  logic meas_go;
  logic signed [31:0] v_sc, i_sc, v_cal, i_cal, v_flt, i_flt;
  logic [5:0] cond;

  // ========================================================
  // Configuration capture
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      for (int i = 0; i < `RPP_CHANNELS; i++) begin
        cfg_q[i] <= CFG_DEFAULT; // [RULE3]
        alpha_q[i] <= `RPP_ALPHA_UNITY;
      end
      poly_q <= '0;
      err_q <= '0;
    end else if (cfg_valid) begin
      cfg_q[cfg_channel] <= cfg_in; // [RULE1] [RULE4] [RULE9]
      // Terms are read only here, so a later table edit needs
      // a new configuration to take effect.
      poly_q[cfg_channel] <= cfg_in.user_correction_enable ?
        cal_table[cfg_channel] : '0; // [RULE15] [RULE16] [RULE20]
      alpha_q[cfg_channel] <= rpp_alpha(cfg_in.filter_ms); // [RULE12]
      err_q[cfg_channel] <= rpp_cfg_bad(cfg_in); // [RULE5] [RULE10] [RULE11]
    end
  end

  // ========================================================
  // Shared datapath for the channel being measured
  always_comb begin
    c = cfg_q[meas_channel];
    meas_go = meas_valid && !c.disable_channel; // [RULE2]
    v_sc = rpp_scale(meas_in.v_rms, c.voltage.range_select,
                     c.voltage.scaling); // [RULE6]
    i_sc = rpp_scale(meas_in.i_rms, c.current.range_select,
                     c.current.scaling); // [RULE6]
    v_cal = c.user_correction_enable ?
      rpp_poly(v_sc, poly_q[meas_channel].voltage) : v_sc; // [RULE17] [RULE18]
    i_cal = c.user_correction_enable ?
      rpp_poly(i_sc, poly_q[meas_channel].current) : i_sc; // [RULE17] [RULE18]
    // First sample after configuration seeds the filter
    v_flt = seed_q[meas_channel] ? v_cal :
      rpp_filter(signed'(filt_q[meas_channel][0]), v_cal,
                 alpha_q[meas_channel]); // [RULE22]
    i_flt = seed_q[meas_channel] ? i_cal :
      rpp_filter(signed'(filt_q[meas_channel][1]), i_cal,
                 alpha_q[meas_channel]); // [RULE22]
    cond[`RPP_V_CLIP] = meas_in.v_peak >=
      rpp_fs_peak(c.voltage.range_select); // [RULE21]
    cond[`RPP_I_CLIP] = meas_in.i_peak >=
      rpp_fs_peak(c.current.range_select); // [RULE21]
    cond[`RPP_V_HIGH] = v_flt >= c.voltage.high_level; // [RULE7]
    cond[`RPP_I_HIGH] = i_flt >= c.current.high_level; // [RULE7]
    cond[`RPP_V_LOW] = v_flt <= c.voltage.low_level; // [RULE8]
    cond[`RPP_I_LOW] = i_flt <= c.current.low_level; // [RULE8]
  end

  // ========================================================
  // Filter state
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      filt_q <= '0;
      seed_q <= '1;
    end else begin
      if (meas_go) begin
        filt_q[meas_channel][0] <= v_flt;
        filt_q[meas_channel][1] <= i_flt;
        seed_q[meas_channel] <= 1'b0;
      end
      if (cfg_valid) begin
        seed_q[cfg_channel] <= 1'b1;
      end
      for (int i = 0; i < `RPP_CHANNELS; i++) begin
        if (cfg_q[i].disable_channel) begin
          filt_q[i] <= '0; // [RULE2]
        end
      end
    end
  end

  // ========================================================
  // Alarms, with latching and unlatch toggles
  assign tog = unlatch_table ^ unl_prev_q; // [RULE14]

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      unl_prev_q <= '0;
    end else begin
      unl_prev_q <= unlatch_table;
    end
  end

  // A condition seen in the same cycle as a toggle keeps the
  // alarm set; the toggle only clears what is no longer true.
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      alarm_q <= '0;
    end else begin
      for (int i = 0; i < `RPP_CHANNELS; i++) begin
        if (cfg_q[i].disable_channel) begin
          alarm_q[i] <= '0; // [RULE2]
        end else if (meas_go && meas_channel == 3'(i)) begin
          alarm_q[i] <= cond | (cfg_q[i].latch_enable ?
            (alarm_q[i] & ~tog[i]) : 6'h0); // [RULE13] [RULE14]
        end else if (cfg_q[i].latch_enable) begin
          alarm_q[i] <= alarm_q[i] & ~tog[i]; // [RULE14]
        end
      end
    end
  end

  // ========================================================
  // Result table
  always_comb begin
    for (int i = 0; i < `RPP_CHANNELS; i++) begin
      result[i].voltage_rms = signed'(filt_q[i][0]);
      result[i].current_rms = signed'(filt_q[i][1]);
      result[i].alarms = alarm_q[i];
      result[i].config_error = err_q[i];
      result[i].active = !cfg_q[i].disable_channel;
    end
  end

  // ========================================================
  // Checks
  a_high_alarm: assert property (@(posedge clock) disable iff (rst)
    (meas_go && v_flt >= c.voltage.high_level)
    |=> alarm_q[$past(meas_channel)][`RPP_V_HIGH]) // [RULE7]
    else $error("voltage high alarm not raised");

  a_low_alarm: assert property (@(posedge clock) disable iff (rst)
    (meas_go && i_flt <= c.current.low_level)
    |=> alarm_q[$past(meas_channel)][`RPP_I_LOW]) // [RULE8]
    else $error("current low alarm not raised");

  a_clip_alarm: assert property (@(posedge clock) disable iff (rst)
    (meas_go && meas_in.v_peak >= rpp_fs_peak(c.voltage.range_select))
    |=> alarm_q[$past(meas_channel)][`RPP_V_CLIP]) // [RULE21]
    else $error("voltage clip alarm not raised");

  a_scale_nominal: assert property (@(posedge clock) disable iff (rst)
    (meas_go && c.voltage.range_select == `RPP_RANGE_2V5
     && meas_in.v_rms == `RPP_NOM_2V5)
    |-> v_sc == signed'({8'h0, c.voltage.scaling})) // [RULE6]
    else $error("nominal input not scaled to scaling value");

  a_raw_report: assert property (@(posedge clock) disable iff (rst)
    (meas_go && !c.user_correction_enable && seed_q[meas_channel])
    |=> filt_q[$past(meas_channel)][0] == $past(v_sc)) // [RULE18]
    else $error("uncorrected reading altered");

  a_phase_error: assert property (@(posedge clock) disable iff (rst)
    (cfg_valid && !cfg_in.line_60hz
     && cfg_in.phase_hundredths > 16'sh02EE)
    |=> err_q[$past(cfg_channel)]) // [RULE11]
    else $error("phase limit error not flagged");

  for (genvar g = 0; g < `RPP_CHANNELS; g++) begin : g_chk
    a_disable_quiet: assert property (@(posedge clock)
      disable iff (rst) cfg_q[g].disable_channel
      |=> alarm_q[g] == 6'h0 && filt_q[g] == '0) // [RULE2]
      else $error("disabled channel still active");

    a_latch_hold: assert property (@(posedge clock) disable iff (rst)
      (cfg_q[g].latch_enable && !cfg_q[g].disable_channel
       && tog[g] == 6'h0 && !(cfg_valid && cfg_channel == 3'(g)))
      |=> ($past(alarm_q[g]) & ~alarm_q[g]) == 6'h0) // [RULE13]
      else $error("latched alarm dropped");

    a_unlatch_clear: assert property (@(posedge clock)
      disable iff (rst)
      (cfg_q[g].latch_enable && tog[g] != 6'h0
       && !(meas_valid && meas_channel == 3'(g)))
      |=> (alarm_q[g] & $past(tog[g])) == 6'h0) // [RULE14]
      else $error("unlatch toggle did not clear alarm");
  end

endmodule

// ### verification/rpp_controller_model.sv
// Controller model that holds the output table: terms and unlatch bits
`timescale 1ns/10ps
module rpp_controller_model (
  input wire logic clock,
  input wire logic rst,
  input wire logic tog_req,
  input wire logic [2:0] tog_ch,
  input wire logic [5:0] tog_bits,
  input wire logic cal_we,
  input wire logic [2:0] cal_ch,
  input wire rpp_pkg::rpp_cal_s cal_val,
  output rpp_pkg::rpp_cal_s [7:0] cal_table,
  output logic [7:0][5:0] unlatch_table
);
  import rpp_pkg::*;

  // ==========================================================
  // Unlatch bits
  // A level flip, not a pulse: the block reacts to any edge
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      unlatch_table <= '0;
    end else if (tog_req) begin
      unlatch_table[tog_ch] <= unlatch_table[tog_ch] ^ tog_bits;
    end
  end

  // ==========================================================
  // Correction terms
  // Held as levels; the block only reads them at a config write
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      cal_table <= '0;
    end else if (cal_we) begin
      cal_table[cal_ch] <= cal_val;
    end
  end
endmodule

// ### verification/rpp_channel_postprocess_tb.sv
// Self-checking testbench for the RMS channel post-processing block
`timescale 1ns/10ps
`include "rpp_defs.svh"
`define CHECK(got, exp, msg) \
  begin comparisons++; if ((got) !== (exp)) begin error_cnt++; \
  $display("[FAIL] %0t %s", $time, msg); end end
module rpp_channel_postprocess_tb;
  import rpp_pkg::*;
  logic clock = 1'b0;
  logic rst = 1'b1;
  logic cfg_valid = 1'b0;
  logic [2:0] cfg_channel = 3'h0;
  rpp_chan_cfg_s cfg_in = '0;
  logic meas_valid = 1'b0;
  logic [2:0] meas_channel = 3'h0;
  rpp_meas_s meas_in = '0;
  logic tog_req = 1'b0;
  logic [2:0] tog_ch = 3'h0;
  logic [5:0] tog_bits = 6'h00;
  logic cal_we = 1'b0;
  logic [2:0] cal_ch = 3'h0;
  rpp_cal_s cal_val = '0;
  rpp_cal_s [7:0] cal_table;
  logic [7:0][5:0] unlatch_table;
  rpp_result_s [7:0] result;
  int error_cnt = 0;
  int comparisons = 0;

  always #20 clock = ~clock;

  rpp_channel_postprocess i_rpp_channel_postprocess (.clock(clock),
    .rst(rst), .cfg_valid(cfg_valid), .cfg_channel(cfg_channel),
    .cfg_in(cfg_in), .cal_table(cal_table), .unlatch_table(unlatch_table),
    .meas_valid(meas_valid), .meas_channel(meas_channel),
    .meas_in(meas_in), .result(result));
  rpp_controller_model i_rpp_controller_model (.clock(clock), .rst(rst),
    .tog_req(tog_req), .tog_ch(tog_ch), .tog_bits(tog_bits),
    .cal_we(cal_we), .cal_ch(cal_ch), .cal_val(cal_val),
    .cal_table(cal_table), .unlatch_table(unlatch_table));

  // ==========================================================
  // Helpers
  function automatic rpp_chan_cfg_s base_cfg(logic [2:0] vr, logic [2:0] ir);
    rpp_chan_cfg_s c;
    c = '0;
    c.voltage.range_select = vr;
    c.current.range_select = ir;
    c.voltage.scaling = `RPP_SCALE_DEFAULT;
    c.current.scaling = `RPP_SCALE_DEFAULT;
    c.voltage.high_level = 32'sh7FFFFFFF;
    c.current.high_level = 32'sh7FFFFFFF;
    c.voltage.low_level = 32'sh80000000;
    c.current.low_level = 32'sh80000000;
    c.line_60hz = 1'b1;
    return c;
  endfunction

  task automatic do_cfg(input logic [2:0] ch, input rpp_chan_cfg_s c);
    @(negedge clock);
    cfg_valid = 1'b1;
    cfg_channel = ch;
    cfg_in = c;
    @(negedge clock);
    cfg_valid = 1'b0;
    @(negedge clock);
  endtask

  task automatic do_meas(input logic [2:0] ch,
                         input logic [15:0] v, vp, i, ip);
    @(negedge clock);
    meas_valid = 1'b1;
    meas_channel = ch;
    meas_in = {v, vp, i, ip};
    @(negedge clock);
    meas_valid = 1'b0;
    @(negedge clock);
  endtask

  task automatic put_cal(input logic [2:0] ch, input rpp_cal_s t);
    @(negedge clock);
    cal_we = 1'b1;
    cal_ch = ch;
    cal_val = t;
    @(negedge clock);
    cal_we = 1'b0;
  endtask

  // ==========================================================
  // Scenarios
  task automatic t_reset();
    for (int k = 0; k < 8; k++)
      `CHECK(result[k], 72'h000000000000000001, "reset state")
    do_meas(3'h7, 16'h1388, 16'h0000, 16'h0000, 16'h0000);
    `CHECK(result[7].voltage_rms, 32'sh00001388, "default range")
  endtask

  task automatic t_ranges();
    rpp_chan_cfg_s c;
    logic [15:0] nom[4];
    logic [15:0] pk[4];
    nom = '{`RPP_NOM_5V0, `RPP_NOM_2V5, `RPP_NOM_1V0, `RPP_NOM_0V5};
    pk = '{`RPP_FS_PK_5V0, `RPP_FS_PK_2V5, `RPP_FS_PK_1V0, `RPP_FS_PK_0V5};
    for (int k = 0; k < 4; k++) begin
      c = base_cfg(3'(k + 1), 3'(4 - k));
      c.voltage.high_level = 32'sh00001388;
      c.voltage.low_level = 32'sh00001387;
      c.current.high_level = 32'sh00001389;
      c.current.low_level = 32'sh00001388;
      do_cfg(3'h0, c);
      do_meas(3'h0, nom[k], pk[k], nom[3 - k], pk[3 - k] - 16'h0001);
      `CHECK(result[0].voltage_rms, 32'sh00001388, "v scale")
      `CHECK(result[0].current_rms, 32'sh00001388, "i scale")
      `CHECK(result[0].alarms, 6'h23, "alarm set")
    end
  endtask

  task automatic t_cfg_err();
    logic [35:0] tbl[10];
    rpp_chan_cfg_s c;
    // Entries: 60 Hz, phase, filter, range, expected error
    tbl = '{{1'h0, 16'h02EE, 15'h0000, 3'h1, 1'h0},
      {1'h0, 16'h02EF, 15'h0000, 3'h1, 1'h1},
      {1'h0, 16'hFD12, 15'h0000, 3'h1, 1'h0},
      {1'h1, 16'h0384, 15'h0000, 3'h1, 1'h0},
      {1'h1, 16'h0385, 15'h0000, 3'h1, 1'h1},
      {1'h1, 16'hFC7B, 15'h0000, 3'h1, 1'h1},
      {1'h1, 16'h0000, 15'h4E84, 3'h1, 1'h0},
      {1'h1, 16'h0000, 15'h4E85, 3'h1, 1'h1},
      {1'h1, 16'h0000, 15'h0000, 3'h0, 1'h1},
      {1'h1, 16'h0000, 15'h0000, 3'h5, 1'h1}};
    for (int k = 0; k < 10; k++) begin
      c = base_cfg(tbl[k][3:1], 3'h1);
      {c.line_60hz, c.phase_hundredths, c.filter_ms} = tbl[k][35:4];
      do_cfg(3'h1, c);
      `CHECK(result[1].config_error, tbl[k][0], "cfg error")
      `CHECK(result[1].active, 1'b1, "still active")
    end
  endtask

  task automatic t_latch();
    rpp_chan_cfg_s c;
    c = base_cfg(3'h1, 3'h1);
    c.voltage.high_level = 32'sh00000FA0;
    do_cfg(3'h2, c);
    do_meas(3'h2, 16'h1388, 16'h0000, 16'h0000, 16'h0000);
    do_meas(3'h2, 16'h03E8, 16'h0000, 16'h0000, 16'h0000);
    `CHECK(result[2].alarms[1], 1'b0, "unlatched follows")
    c.latch_enable = 1'b1;
    do_cfg(3'h2, c);
    do_meas(3'h2, 16'h1388, 16'h0000, 16'h0000, 16'h0000);
    do_meas(3'h2, 16'h03E8, 16'h0000, 16'h0000, 16'h0000);
    `CHECK(result[2].alarms[1], 1'b1, "latched holds")
    @(negedge clock);
    tog_req = 1'b1;
    tog_ch = 3'h2;
    tog_bits = 6'h02;
    @(negedge clock);
    tog_req = 1'b0;
    repeat (2) @(negedge clock);
    `CHECK(result[2].alarms[1], 1'b0, "toggle clears")
  endtask

  task automatic t_correction();
    rpp_chan_cfg_s c;
    put_cal(3'h3, {32'sh00010000, 32'sh00020000, 32'sh00000064,
      32'sh00000000, 32'sh00000000, 32'sh00000064});
    // Scaling equals the range value, so readings stay in millivolts
    c = base_cfg(3'h1, 3'h1);
    c.user_correction_enable = 1'b1;
    do_cfg(3'h3, c);
    do_meas(3'h3, 16'h0064, 16'h0000, 16'h0000, 16'h0000);
    `CHECK(result[3].voltage_rms, 32'sh0000283C, "poly v")
    `CHECK(result[3].current_rms, 32'sh00000064, "poly i")
    put_cal(3'h3, {32'sh00010000, 32'sh00020000, 32'sh00000000, 96'h0});
    do_meas(3'h3, 16'h0064, 16'h0000, 16'h0000, 16'h0000);
    `CHECK(result[3].voltage_rms, 32'sh0000283C, "terms kept")
    c.user_correction_enable = 1'b0;
    do_cfg(3'h3, c);
    do_meas(3'h3, 16'h0064, 16'h0000, 16'h0000, 16'h0000);
    `CHECK(result[3].voltage_rms, 32'sh00000064, "raw value")
    c.user_correction_enable = 1'b1;
    do_cfg(3'h3, c);
    do_meas(3'h3, 16'h0064, 16'h0000, 16'h0000, 16'h0000);
    `CHECK(result[3].voltage_rms, 32'sh000027D8, "new terms")
  endtask

  task automatic t_filter_disable();
    rpp_chan_cfg_s c;
    c = base_cfg(3'h1, 3'h1);
    c.filter_ms = 15'h0001;
    do_cfg(3'h4, c);
    do_meas(3'h4, 16'h03E8, 16'h0000, 16'h0000, 16'h0000);
    `CHECK(result[4].voltage_rms, 32'sh000003E8, "filter seed")
    do_meas(3'h4, 16'h0BB8, 16'h0000, 16'h0000, 16'h0000);
    `CHECK(result[4].voltage_rms, 32'sh000007D0, "filter step")
    c.disable_channel = 1'b1;
    do_cfg(3'h5, c);
    do_meas(3'h5, 16'h03E8, 16'h0000, 16'h0000, 16'h0000);
    `CHECK(result[5], 72'h000000000000000000, "disabled")
    `CHECK(result[0].voltage_rms, 32'sh00001388, "others kept")
  endtask

  // ==========================================================
  // Run control
  task automatic print_verdict();
    $display("Comparisons %0d, mismatches %0d", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  // Whole run is well under 1000 cycles; allow generous margin
  initial begin
    #(40 * 5000);
    error_cnt++;
    $display("[FAIL] %0t watchdog expired", $time);
    print_verdict();
  end

  initial begin
    repeat (8) @(posedge clock);
    @(negedge clock);
    rst = 1'b0;
    t_reset();
    t_ranges();
    t_cfg_err();
    t_latch();
    t_correction();
    t_filter_disable();
    print_verdict();
  end
endmodule
